//--- src/sdc_pkg.sv
// package: constants and types for delta-sigma conversion control
package sdc_pkg;
  localparam int unsigned RES_W = 5;
  localparam int unsigned DATA_W = 20;
  localparam int unsigned DEC_W = 16;
  localparam int unsigned CNT_W = 2;
  localparam int unsigned FIFO_W = 20;
  localparam int unsigned FIFO_D = 4;
  // pipeline depth of the decimator
  localparam logic [CNT_W-1:0] PRIME_LAST = 2'h3;
  localparam logic [RES_W-1:0] RES_MIN = 5'h08;
  localparam logic [RES_W-1:0] RES_MAX = 5'h14;
  localparam logic [RES_W-1:0] TURBO_MIN_RES = 5'h11;
  localparam logic [DEC_W-1:0] DEC_MIN = 16'h0001;
  localparam logic [DEC_W-1:0] DEC_ONE = 16'h0001;
  typedef enum logic [1:0] {
    SDC_MODE_SINGLE = 2'b00,
    SDC_MODE_MULTI = 2'b01,
    SDC_MODE_CONT = 2'b10,
    SDC_MODE_TURBO = 2'b11
  } sdc_mode_t;
  typedef enum logic [1:0] {
    SDC_ST_IDLE = 2'b00,
    SDC_ST_RUN = 2'b01,
    SDC_ST_WAIT = 2'b10
  } sdc_state_t;
endpackage

//--- src/sdc_fifo.sv
// module: small flop-based result fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sdc_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign o_wr_ready = (cnt_reg != DEPTH_CNT);
  assign o_rd_valid = (cnt_reg != '0);
  assign o_rd_data = mem_reg[rp_reg];

  always_comb begin
    push = i_wr_valid && o_wr_ready;
    pop = o_rd_valid && i_rd_ready;
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wp_next = (wp_reg == LAST_IDX) ? '0 : wp_reg + 1'b1;
    end
    if (pop) begin
      rp_next = (rp_reg == LAST_IDX) ? '0 : rp_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage needs no reset, contents gated by count
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wp_reg] <= i_wr_data;
    end
  end
endmodule
`default_nettype wire

//--- src/sdc_ctrl.sv
// module: delta-sigma conversion sequencer with decimator and result handshake
// Behaviour
// - result depends on last four samples
// - decimation config sets resolution and rate
// - four modes: single, multi, continuous, turbo
// - start by control bit or trigger input
// - done flag and output held until read
// - single: standby, four conversions, fourth gives result
// - single: back to standby after read
// - continuous: three-period priming, then every period
// - multi: reset and re-prime between samples, auto-restart
// - turbo: multi below 17 bits, else reset at start and again on disable
// - completion via status poll or done output
// - decimator turns bitstream into parallel results
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [1:0] i_mode,
  input wire logic [sdc_pkg::RES_W-1:0] i_resolution,
  input wire logic [sdc_pkg::DEC_W-1:0] i_decimation,
  input wire logic i_start_bit,
  input wire logic i_start_trig,
  input wire logic i_mux_changed,
  input wire logic i_mod_bit,
  input wire logic i_result_read,
  output logic o_mod_reset,
  output logic o_busy,
  output logic o_done_status,
  output logic o_done,
  output logic [sdc_pkg::DATA_W-1:0] o_result,
  output logic o_result_valid,
  output logic o_overrun
);
  // ------------------------------------------------------------
  // trigger synchroniser and edge detect
  // ------------------------------------------------------------
  logic trig_s1_reg, trig_s2_reg, trig_s3_reg, trig_lvl_reg;
  logic trig_s1_next, trig_s2_next, trig_s3_next, trig_lvl_next;
  logic trig_rise;

  always_comb begin
    trig_s1_next = i_start_trig;
    trig_s2_next = trig_s1_reg;
    trig_s3_next = trig_s2_reg;
    // level only moves once stages two and three agree
    trig_lvl_next = (trig_s2_reg == trig_s3_reg) ? trig_s3_reg : trig_lvl_reg;
  end
  assign trig_rise = (trig_s2_reg == trig_s3_reg) && trig_s3_reg && !trig_lvl_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
      trig_lvl_reg <= 1'b0;
    end else begin
      trig_s1_reg <= trig_s1_next;
      trig_s2_reg <= trig_s2_next;
      trig_s3_reg <= trig_s3_next;
      trig_lvl_reg <= trig_lvl_next;
    end
  end

  // ------------------------------------------------------------
  // sequencer and decimator
  // ------------------------------------------------------------
  sdc_pkg::sdc_state_t st_reg, st_next;
  sdc_pkg::sdc_mode_t mode_reg, mode_next;
  logic [sdc_pkg::DEC_W-1:0] tick_reg, tick_next, dec_len;
  logic [sdc_pkg::DATA_W-1:0] acc_reg, acc_next;
  logic [sdc_pkg::DATA_W-1:0] stage_reg [3];
  logic [sdc_pkg::DATA_W-1:0] stage_next [3];
  logic [sdc_pkg::CNT_W-1:0] prime_reg, prime_next;
  logic [sdc_pkg::RES_W-1:0] res_reg, res_next, res_clamp;
  logic mod_rst_reg, mod_rst_next;
  logic start_req, period_end, primed, turbo_long;
  logic push_valid, push_ready, fifo_valid;
  logic [sdc_pkg::DATA_W-1:0] push_data, res_mask, sum4;
  logic ovr_reg, ovr_next;

  assign start_req = i_enable && (i_start_bit || trig_rise);
  assign dec_len = (i_decimation < sdc_pkg::DEC_MIN) ? sdc_pkg::DEC_MIN : i_decimation;
  // at or past the end, so a live shrink of the period cannot strand the count
  assign period_end = (tick_reg >= dec_len - sdc_pkg::DEC_ONE);
  assign primed = (prime_reg == sdc_pkg::PRIME_LAST);
  assign turbo_long = (res_reg >= sdc_pkg::TURBO_MIN_RES);
  assign sum4 = acc_reg + sdc_pkg::DATA_W'(i_mod_bit) + stage_reg[0] + stage_reg[1] + stage_reg[2];

  always_comb begin
    res_clamp = i_resolution;
    if (i_resolution < sdc_pkg::RES_MIN) begin
      res_clamp = sdc_pkg::RES_MIN;
    end else if (i_resolution > sdc_pkg::RES_MAX) begin
      res_clamp = sdc_pkg::RES_MAX;
    end
    // keep only the configured number of result bits
    res_mask = ~(sdc_pkg::DATA_W'({sdc_pkg::DATA_W{1'b1}}) << res_reg);
  end

  always_comb begin
    st_next = st_reg;
    mode_next = mode_reg;
    res_next = res_reg;
    tick_next = tick_reg;
    acc_next = acc_reg;
    stage_next = stage_reg;
    prime_next = prime_reg;
    mod_rst_next = 1'b0;
    push_valid = 1'b0;
    push_data = sum4 & res_mask;
    ovr_next = ovr_reg;
    case (st_reg)
      sdc_pkg::SDC_ST_IDLE: begin
        if (start_req) begin
          st_next = sdc_pkg::SDC_ST_RUN;
          mode_next = sdc_pkg::sdc_mode_t'(i_mode);
          res_next = res_clamp;
          tick_next = '0;
          acc_next = '0;
          prime_next = '0;
          stage_next = '{default: '0};
          mod_rst_next = 1'b1;
          ovr_next = 1'b0;
        end
      end
      sdc_pkg::SDC_ST_RUN: begin
        // start requests here fall through untouched
        tick_next = tick_reg + sdc_pkg::DEC_ONE;
        acc_next = acc_reg + sdc_pkg::DATA_W'(i_mod_bit);
        if (i_mux_changed) begin
          // drop the partial period so four fresh ones follow
          tick_next = '0;
          acc_next = '0;
          prime_next = '0;
        end else if (period_end) begin
          tick_next = '0;
          acc_next = '0;
          stage_next[2] = stage_reg[1];
          stage_next[1] = stage_reg[0];
          stage_next[0] = acc_reg + sdc_pkg::DATA_W'(i_mod_bit);
          if (!primed) begin
            prime_next = prime_reg + 1'b1;
          end else begin
            push_valid = 1'b1;
            if (!push_ready) begin
              ovr_next = 1'b1;
            end
            case (mode_reg)
              sdc_pkg::SDC_MODE_SINGLE: begin
                st_next = sdc_pkg::SDC_ST_WAIT;
              end
              sdc_pkg::SDC_MODE_CONT: begin
                st_next = sdc_pkg::SDC_ST_RUN;
              end
              sdc_pkg::SDC_MODE_TURBO: begin
                if (!turbo_long) begin
                  prime_next = '0;
                  stage_next = '{default: '0};
                  mod_rst_next = 1'b1;
                end
              end
              default: begin
                prime_next = '0;
                stage_next = '{default: '0};
                mod_rst_next = 1'b1;
              end
            endcase
          end
        end
        if (!i_enable) begin
          st_next = sdc_pkg::SDC_ST_IDLE;
          if (mode_reg == sdc_pkg::SDC_MODE_TURBO && turbo_long) begin
            mod_rst_next = 1'b1;
          end
        end
      end
      sdc_pkg::SDC_ST_WAIT: begin
        // result must have left the buffer and been read
        if (!fifo_valid && !o_result_valid) begin
          st_next = sdc_pkg::SDC_ST_IDLE;
        end
      end
      default: begin
        st_next = sdc_pkg::SDC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg <= sdc_pkg::SDC_ST_IDLE;
      mode_reg <= sdc_pkg::SDC_MODE_SINGLE;
      res_reg <= sdc_pkg::RES_MIN;
      tick_reg <= '0;
      acc_reg <= '0;
      stage_reg <= '{default: '0};
      prime_reg <= '0;
      mod_rst_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      res_reg <= res_next;
      tick_reg <= tick_next;
      acc_reg <= acc_next;
      stage_reg <= stage_next;
      prime_reg <= prime_next;
      mod_rst_reg <= mod_rst_next;
      ovr_reg <= ovr_next;
    end
  end

  // ------------------------------------------------------------
  // result buffer and done handshake
  // ------------------------------------------------------------
  logic [sdc_pkg::DATA_W-1:0] fifo_data;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [sdc_pkg::DATA_W-1:0] res_out_reg, res_out_next;
  logic pop;

  sdc_fifo #(
    .WIDTH(sdc_pkg::FIFO_W),
    .DEPTH(sdc_pkg::FIFO_D)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr_valid(push_valid),
    .o_wr_ready(push_ready),
    .i_wr_data(push_data),
    .o_rd_valid(fifo_valid),
    .i_rd_ready(pop),
    .o_rd_data(fifo_data)
  );

  // head of fifo is staged into the output word; a read frees it
  always_comb begin
    pop = fifo_valid && (!done_reg || i_result_read);
    done_next = done_reg;
    res_out_next = res_out_reg;
    if (pop) begin
      done_next = 1'b1; // new result wins over the read
      res_out_next = fifo_data;
    end else if (i_result_read) begin
      done_next = 1'b0;
    end
    busy_next = (st_next == sdc_pkg::SDC_ST_RUN);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      done_reg <= 1'b0;
      res_out_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
      res_out_reg <= res_out_next;
      busy_reg <= busy_next;
    end
  end

  assign o_done = done_reg;
  assign o_done_status = done_reg;
  assign o_result = res_out_reg;
  assign o_result_valid = done_reg;
  assign o_busy = busy_reg;
  assign o_mod_reset = mod_rst_reg;
  assign o_overrun = ovr_reg;
endmodule
`default_nettype wire

//--- tb/sdc_ctrl_assertions.sv
// checker: port timing of the conversion control
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_start_bit,
  input wire logic i_start_trig,
  input wire logic i_result_read,
  input wire logic o_mod_reset,
  input wire logic o_busy,
  input wire logic o_done_status,
  input wire logic o_done,
  input wire logic [sdc_pkg::DATA_W-1:0] o_result,
  input wire logic o_result_valid
);
  // ------
  // checks
  // ------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_held;
    o_done && !i_result_read && i_enable;
  endsequence
  sequence s_start;
    $rose(o_busy);
  endsequence
  sequence s_quiet;
    !o_done [*4];
  endsequence
  a_flag_pair: assert property (o_done_status == o_done && o_result_valid == o_done)
    else $error("done flags differ");
  a_done_held: assert property (s_held |=> o_done)
    else $error("done fell unread");
  a_result_held: assert property (s_held |=> $stable(o_result))
    else $error("result moved unread");
  a_start_reset: assert property (s_start |-> o_mod_reset)
    else $error("no modulator reset at start");
  a_prime_quiet: assert property (s_start ##0 !o_done |-> s_quiet)
    else $error("result before priming");
  // trigger passes a three-flop synchroniser first
  a_start_cause: assert property (s_start |-> $past(i_start_bit) || $past(i_start_trig, 2) ||
    $past(i_start_trig, 3) || $past(i_start_trig, 4) || $past(i_start_trig, 5) || $past(i_start_trig, 6))
    else $error("start without request");
  a_pulse_short: assert property (o_mod_reset |=> !o_mod_reset)
    else $error("modulator reset too long");
  a_abort_idle: assert property (!i_enable |-> ##2 !o_busy)
    else $error("busy while disabled");
endmodule
bind sdc_ctrl sdc_ctrl_assertions i_sdc_ctrl_assertions (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_enable(i_enable), .i_start_bit(i_start_bit), .i_start_trig(i_start_trig),
  .i_result_read(i_result_read), .o_mod_reset(o_mod_reset), .o_busy(o_busy),
  .o_done_status(o_done_status), .o_done(o_done), .o_result(o_result), .o_result_valid(o_result_valid));
`default_nettype wire

//--- tb/sdc_reader.sv
// partner: processor or dma side collecting each finished result
`timescale 1ns/1ps
`default_nettype none
module sdc_reader (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_done,
  input wire logic [3:0] i_lag,
  output logic o_read
);
  // ------
  // reader
  // ------
  logic [3:0] wait_reg;
  // lag lets the bench pick a prompt or a slow consumer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_done || o_read) begin
      wait_reg <= 4'h0;
      o_read <= 1'b0;
    end else if (wait_reg >= i_lag) begin
      o_read <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/sdc_ctrl_tb.sv
// testbench: sequencing, results and buffering of the conversion control
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_tb;
  // -------
  // harness
  // -------
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, sbit = 1'b0, trig = 1'b0, mux = 1'b0, mb = 1'b0;
  logic prev_busy = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [4:0] res = 5'h08;
  logic [15:0] dec = 16'h0001;
  logic [3:0] lag = 4'h0;
  logic rd, mrst, busy, dstat, done, rv, ovr;
  logic [19:0] result;
  logic [1:0] mt [5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h2};
  logic [4:0] rt [5] = '{5'h0c, 5'h14, 5'h14, 5'h10, 5'h08};
  int err_total = 0;
  int checks = 0;
  int nres, nrst, t, lo;
  always #10 clk = ~clk;
  sdc_ctrl i_sdc_ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_enable(en), .i_mode(mode), .i_resolution(res),
    .i_decimation(dec), .i_start_bit(sbit), .i_start_trig(trig), .i_mux_changed(mux), .i_mod_bit(mb),
    .i_result_read(rd), .o_mod_reset(mrst), .o_busy(busy), .o_done_status(dstat), .o_done(done),
    .o_result(result), .o_result_valid(rv), .o_overrun(ovr));
  sdc_reader i_sdc_reader (.i_clk(clk), .i_rst_n(rst_n), .i_done(done), .i_lag(lag), .o_read(rd));
  function automatic logic [19:0] exp_res(logic [15:0] d, logic b);
    return b ? {2'h0, d, 2'h0} : 20'h0;
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_done(logic v, int lim);
    while (done !== v) begin
      @(posedge clk);
      t++;
      if (t > lim) begin
        check("timeout", 0, 1);
        wrap_up();
      end
    end
  endtask
  task automatic setup(logic [1:0] m, logic [4:0] r, logic [3:0] l);
    @(posedge clk);
    mode <= m;
    res <= r;
    lag <= l;
    dec <= 16'($urandom_range(6, 1));
    mb <= 1'($urandom_range(1));
    repeat (3) @(posedge clk);
  endtask
  task automatic go(logic pin);
    if (pin)
      trig <= 1'b1;
    else
      sbit <= 1'b1;
    // the pin filter needs the level to stand for at least two samples
    repeat (pin ? 3 : 1) @(posedge clk);
    trig <= 1'b0;
    sbit <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (done === 1'b1 && rd === 1'b1) begin
      nres++;
      check("result", result, exp_res(dec, mb));
      check("status", {dstat, rv}, 2'b11);
    end
    if (mrst === 1'b1 && prev_busy === 1'b1)
      nrst++;
    prev_busy <= busy;
  end
  // ---------
  // sequences
  // ---------
  initial begin
    void'($urandom(56461));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    en <= 1'b1;
    // single sample, extra start and input switch in mid-priming
    for (int k = 0; k < 3; k++) begin
      setup(2'h0, 5'h08, 4'($urandom_range(7)));
      nres = 0;
      go(k == 1);
      lo = (k == 2) ? 6 * dec : 4 * dec;
      repeat (2 * dec) @(posedge clk);
      sbit <= 1'b1;
      mux <= (k == 2);
      @(posedge clk);
      sbit <= 1'b0;
      mux <= 1'b0;
      t = 2 * dec + 1;
      wait_done(1'b1, 200);
      check("latency", t >= lo && t <= 8 * dec + 12, 1);
      t = 0;
      wait_done(1'b0, 64);
      check("reads", nres, 1);
      repeat (4 * dec + 8) @(posedge clk);
      check("standby", {busy, done}, 2'b00);
    end
    // free-running modes; last one overfills the fifo
    for (int k = 0; k < 5; k++) begin
      setup(mt[k], rt[k], (k == 4) ? 4'hf : 4'($urandom_range(3)));
      nres = 0;
      nrst = 0;
      go(k[0]);
      repeat (60 * dec) @(posedge clk);
      check("results", nres > 0, 1);
      if (mt[k] == 2'h2 || rt[k] >= 5'h11)
        check("resets", nrst, 0);
      else
        check("resets", nrst >= nres - 1, 1);
      if (k == 4)
        check("overrun", ovr, 1);
      en <= 1'b0;
      // let the drop reach the design and busy settle before looking
      repeat (2) @(posedge clk);
      t = 0;
      wait_done(1'b0, 400);
      check("drained", busy, 0);
      en <= 1'b1;
    end
    setup(2'h0, 5'h14, 4'h0);
    go(1'b0);
    repeat (2) @(posedge clk);
    check("overrun clear", ovr, 0);
    t = 0;
    wait_done(1'b1, 200);
    wait_done(1'b0, 264);
    wrap_up();
  end
endmodule
`default_nettype wire
